//--- test_usb_desc_source.sv
// self-checking bench for the descriptor source
// host model is usb_host_model; checker bound below
`timescale 1ns/1ns
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin \
   miscompares++; $display("Error %s exp %h got %h", nm, e, a); end end
module test_usb_desc_source
   import usb_desc_pkg::*;
;
   logic ref_clk = 1'b0, nrst = 1'b0, highSpeed = 1'b0, selfPowered = 1'b0;
   logic nvValid = 1'b0, nvHsPowerValid = 1'b0, nvFsPowerValid = 1'b0;
   logic reqStart = 1'b0, stall = 1'b0, clr = 1'b0;
   logic [1:0] reqSel = 2'h0;
   logic [15:0] reqLen = 16'h0000;
   logic [7:0] nvHsInterval = 8'h0a, nvFsInterval = 8'h0b, nvHsStrIdx = 8'h05;
   logic [7:0] nvFsStrIdx = 8'h06, nvHsAttr = 8'ha0, nvFsAttr = 8'hc0;
   logic [7:0] nvHsPower = 8'h32, nvFsPower = 8'h64, dataByte;
   logic dataReady, dataValid, dataLast, busy;
   int miscompares = 0, n_compared = 0;
   always #5 ref_clk = ~ref_clk;
   usb_desc_source u_dut (.ref_clk, .nrst, .highSpeed, .selfPowered, .nvValid,
      .nvHsInterval, .nvFsInterval, .nvHsStrIdx, .nvFsStrIdx, .nvHsAttr,
      .nvFsAttr, .nvHsPowerValid, .nvFsPowerValid, .nvHsPower, .nvFsPower,
      .reqStart, .reqSel, .reqLen, .dataReady, .dataByte, .dataValid,
      .dataLast, .busy);
   usb_host_model u_host (.ref_clk, .nrst, .stall, .clr, .dataValid,
      .dataByte, .dataReady);
   function automatic logic [7:0] expB(input logic [1:0] s, input int o);
      logic [15:0] m;
      logic [7:0] e [0:8];
      logic hs;
      hs = highSpeed;
      m = s == 2'h2 ? MPS_INTR : hs ? MPS_HIGH : MPS_FULL;
      e = '{EP_LEN, EP_TYPE, s == 2'h0 ? EP_BULK_IN_ADDR : s == 2'h1 ?
         EP_BULK_OUT_ADDR : EP_INTR_ADDR, s == 2'h2 ? EP_ATTR_INTR :
         EP_ATTR_BULK, m[7:0], m[15:8], s != 2'h2 ? EP_BULK_INTERVAL :
         nvValid ? (hs ? nvHsInterval : nvFsInterval) : hs ?
         INTR_HS_DEFAULT : INTR_FS_DEFAULT, BYTE_ZERO, BYTE_ZERO};
      if (s == 2'h3)
         e = '{OSC_LEN, OSC_TYPE, OSC_TOTAL[7:0], OSC_TOTAL[15:8],
            OSC_NUM_IF, OSC_CFG_VALUE, !nvValid ? OSC_STR_DEFAULT : hs ?
            nvFsStrIdx : nvHsStrIdx, !nvValid ? OSC_ATTR_DEFAULT : hs ?
            nvFsAttr : nvHsAttr, nvValid && (hs ? nvFsPowerValid :
            nvHsPowerValid) ? (hs ? nvFsPower : nvHsPower) : selfPowered ?
            POWER_SELF : POWER_BUS};
      return e[o];
   endfunction
   task automatic stop_test;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic getDesc(input logic [1:0] s, input logic [15:0] l);
      logic [7:0] c;
      int k;
      c = s == 2'h3 ? OSC_LEN : EP_LEN;
      if (l < {8'h00, c})
         c = l[7:0];
      @(posedge ref_clk);
      clr <= 1'b1;
      reqSel <= s;
      reqLen <= l;
      reqStart <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      reqStart <= 1'b0;
      #1;
      for (k = 0; k < 60 && busy !== 1'b0; k++)
         @(posedge ref_clk) #1;
      `CHK("count", c, u_host.n)
      for (k = 0; k < c; k++)
         `CHK("byte", expB(s, k), u_host.rx[k])
      `CHK("last", 1'b0, busy)
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         @(posedge ref_clk);
         highSpeed <= i[0];
         nvValid <= i[1];
         selfPowered <= i[2];
         stall <= i[3];
         nvHsPowerValid <= i[3];
         nvFsPowerValid <= ~i[3];
         repeat (3) @(posedge ref_clk);
         for (int s = 0; s < 4; s++)
            getDesc(2'(s), 16'hffff);
      end
      // start pulse while busy must be ignored
      fork
         getDesc(2'h2, 16'h0003);
         begin
            repeat (3) @(posedge ref_clk);
            reqSel <= 2'h3;
            reqLen <= 16'h0009;
            reqStart <= 1'b1;
            @(posedge ref_clk);
            reqStart <= 1'b0;
         end
      join
      getDesc(2'h3, 16'h0002);
      getDesc(2'h2, 16'h0001);
      getDesc(2'h1, 16'h0000);
      stop_test;
   end
   initial begin
      #100000;
      miscompares++;
      stop_test;
   end
endmodule // test_usb_desc_source
bind usb_desc_source usb_desc_source_assertions u_chk (.ref_clk, .nrst,
   .reqStart, .reqSel, .reqLen, .dataReady, .dataByte, .dataValid,
   .dataLast, .busy);

//--- usb_desc_pkg.sv
// constants for the endpoint and other-speed descriptor source
// assumes one 100 MHz controller clock shared by all users
package usb_desc_pkg;
   localparam logic [7:0] EP_LEN = 8'h07;
   localparam logic [7:0] EP_TYPE = 8'h05;
   localparam logic [7:0] EP_BULK_IN_ADDR = 8'h81;
   localparam logic [7:0] EP_BULK_OUT_ADDR = 8'h02;
   localparam logic [7:0] EP_INTR_ADDR = 8'h83;
   localparam logic [7:0] EP_ATTR_BULK = 8'h02;
   localparam logic [7:0] EP_ATTR_INTR = 8'h03;
   localparam logic [7:0] EP_BULK_INTERVAL = 8'h00;
   localparam logic [15:0] MPS_FULL = 16'h0040;
   localparam logic [15:0] MPS_HIGH = 16'h0200;
   localparam logic [15:0] MPS_INTR = 16'h0010;
   localparam logic [7:0] INTR_HS_DEFAULT = 8'h04;
   localparam logic [7:0] INTR_FS_DEFAULT = 8'h01;
   localparam logic [7:0] OSC_LEN = 8'h09;
   localparam logic [7:0] OSC_TYPE = 8'h07;
   localparam logic [15:0] OSC_TOTAL = 16'h0027;
   localparam logic [7:0] OSC_NUM_IF = 8'h01;
   localparam logic [7:0] OSC_CFG_VALUE = 8'h01;
   localparam logic [7:0] OSC_STR_DEFAULT = 8'h00;
   localparam logic [7:0] OSC_ATTR_DEFAULT = 8'he0;
   localparam logic [7:0] POWER_SELF = 8'h01;
   localparam logic [7:0] POWER_BUS = 8'hfa;
   // descriptor byte offsets
   localparam logic [7:0] OFS_LEN = 8'h00;
   localparam logic [7:0] OFS_TYPE = 8'h01;
   localparam logic [7:0] OFS_ADDR = 8'h02;
   localparam logic [7:0] OFS_ATTR = 8'h03;
   localparam logic [7:0] OFS_MPS_LO = 8'h04;
   localparam logic [7:0] OFS_MPS_HI = 8'h05;
   localparam logic [7:0] OFS_INTERVAL = 8'h06;
   localparam logic [7:0] OFS_TOT_LO = 8'h02;
   localparam logic [7:0] OFS_TOT_HI = 8'h03;
   localparam logic [7:0] OFS_NUM_IF = 8'h04;
   localparam logic [7:0] OFS_CFG_VAL = 8'h05;
   localparam logic [7:0] OFS_STR = 8'h06;
   localparam logic [7:0] OFS_CFG_ATTR = 8'h07;
   localparam logic [7:0] OFS_POWER = 8'h08;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] ONE_BYTE = 8'h01;
   localparam logic [7:0] TWO_BYTES = 8'h02;
   typedef enum logic [1:0] {
      SEL_BULK_IN = 2'h0,
      SEL_BULK_OUT = 2'h1,
      SEL_INTR = 2'h2,
      SEL_OTHER_SPEED = 2'h3
   } desc_sel_t;
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_SEND = 1'b1
   } desc_state_t;
endpackage

//--- usb_desc_source.sv
// byte-serial source for the bulk-in, bulk-out, interrupt endpoint and
// other-speed configuration descriptors
// assumes the control engine and nonvolatile loader share ref_clk;
// selfPowered is a board pin and is synchronised here
//
// Operation
// R1 - Bulk-in endpoint descriptor is fixed: 07h, 05h, 81h, 02h, interval 00h.
// R2 - Bulk-in max packet is 64 bytes at full speed and 512 at high speed.
// R3 - Bulk-out descriptor is fixed: 07h, 05h, 02h, 02h, interval 00h.
// R4 - Bulk-out max packet is 64 bytes at full speed and 512 at high speed.
// R5 - Bulk intervals read 00h and the host ignores them.
// R6 - Interrupt endpoint: 07h, 05h, 83h, 03h, packet 10h, stored interval.
// R7 - Interrupt interval is kept per speed, default 04h high, 01h full.
// R8 - Other-speed descriptor has length 09h and fixed type 07h.
// R9 - Other-speed total length reads 0027h.
// R10 - Interface count 01h, config value 01h, string index 00h unless stored.
// R11 - Stored length, total, interface count, config value stay default.
// R12 - Other-speed attributes default to E0h; stored config flags win.
// R13 - Max power defaults to 01h self or FAh bus powered unless stored.
// R14 - Other-speed fields use the stored values of the opposite speed.
// R15 - Bytes go out in offset order, stopping at min of length and request.
`timescale 1ns/1ns
module usb_desc_source
   import usb_desc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic highSpeed,
   input wire logic selfPowered,
   input wire logic nvValid,
   input wire logic [7:0] nvHsInterval,
   input wire logic [7:0] nvFsInterval,
   input wire logic [7:0] nvHsStrIdx,
   input wire logic [7:0] nvFsStrIdx,
   input wire logic [7:0] nvHsAttr,
   input wire logic [7:0] nvFsAttr,
   input wire logic nvHsPowerValid,
   input wire logic nvFsPowerValid,
   input wire logic [7:0] nvHsPower,
   input wire logic [7:0] nvFsPower,
   input wire logic reqStart,
   input wire logic [1:0] reqSel,
   input wire logic [15:0] reqLen,
   input wire logic dataReady,
   output logic [7:0] dataByte,
   output logic dataValid,
   output logic dataLast,
   output logic busy
);
   logic selfMeta;
   logic selfSync;
   desc_state_t state;
   desc_state_t next_state;
   desc_sel_t sel;
   desc_sel_t next_sel;
   logic [7:0] idx;
   logic [7:0] next_idx;
   logic [7:0] limit;
   logic [7:0] next_limit;
   logic [7:0] next_dataByte;
   logic next_dataValid;
   logic next_dataLast;
   logic next_busy;
   logic [7:0] intrHs;
   logic [7:0] intrFs;
   logic [7:0] oscStr;
   logic [7:0] oscAttr;
   logic [7:0] oscPower;
   logic [15:0] bulkMps;
   logic [7:0] reqDescLen;
   logic [7:0] reqLimit;

   // two-flop synchroniser for the power-mode pin
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         selfMeta <= 1'b0;
         selfSync <= 1'b0;
      end else begin
         selfMeta <= selfPowered;
         selfSync <= selfMeta;
      end
   end

   // per-speed interrupt intervals with fallbacks
   assign intrHs = nvValid ? nvHsInterval : INTR_HS_DEFAULT; // R7
   assign intrFs = nvValid ? nvFsInterval : INTR_FS_DEFAULT; // R7
   assign bulkMps = highSpeed ? MPS_HIGH : MPS_FULL; // R2 R4

   // other-speed fields come from the opposite speed's stored set
   always_comb begin
      if (!nvValid) begin
         oscStr = OSC_STR_DEFAULT; // R10
         oscAttr = OSC_ATTR_DEFAULT; // R12
      end else if (highSpeed) begin
         oscStr = nvFsStrIdx; // R14
         oscAttr = nvFsAttr; // R12 R14
      end else begin
         oscStr = nvHsStrIdx; // R14
         oscAttr = nvHsAttr; // R12 R14
      end
      oscPower = selfSync ? POWER_SELF : POWER_BUS; // R13
      if (nvValid && highSpeed && nvFsPowerValid) begin
         oscPower = nvFsPower; // R13 R14
      end else if (nvValid && !highSpeed && nvHsPowerValid) begin
         oscPower = nvHsPower; // R13 R14
      end
   end

   function automatic logic [7:0] descLen(input desc_sel_t s);
      descLen = (s == SEL_OTHER_SPEED) ? OSC_LEN : EP_LEN; // R1 R3 R6 R8
   endfunction

   function automatic logic [7:0] epByte(
      input logic [7:0] ofs,
      input logic [7:0] addr,
      input logic [7:0] attr,
      input logic [15:0] mps,
      input logic [7:0] ival
   );
      case (ofs)
         OFS_LEN: epByte = EP_LEN;
         OFS_TYPE: epByte = EP_TYPE;
         OFS_ADDR: epByte = addr;
         OFS_ATTR: epByte = attr;
         OFS_MPS_LO: epByte = mps[7:0];
         OFS_MPS_HI: epByte = mps[15:8];
         OFS_INTERVAL: epByte = ival;
         default: epByte = BYTE_ZERO;
      endcase
   endfunction

   function automatic logic [7:0] descByte(
      input desc_sel_t s,
      input logic [7:0] ofs
   );
      case (s)
         SEL_BULK_IN: descByte = epByte(ofs, EP_BULK_IN_ADDR,
            EP_ATTR_BULK, bulkMps, EP_BULK_INTERVAL); // R1 R2 R5
         SEL_BULK_OUT: descByte = epByte(ofs, EP_BULK_OUT_ADDR,
            EP_ATTR_BULK, bulkMps, EP_BULK_INTERVAL); // R3 R4 R5
         SEL_INTR: descByte = epByte(ofs, EP_INTR_ADDR, EP_ATTR_INTR,
            MPS_INTR, highSpeed ? intrHs : intrFs); // R6 R7
         default: begin
            case (ofs)
               OFS_LEN: descByte = OSC_LEN; // R8
               OFS_TYPE: descByte = OSC_TYPE; // R8
               OFS_TOT_LO: descByte = OSC_TOTAL[7:0]; // R9
               OFS_TOT_HI: descByte = OSC_TOTAL[15:8]; // R9
               // stored copies must equal defaults, so hardwired
               OFS_NUM_IF: descByte = OSC_NUM_IF; // R10 R11
               OFS_CFG_VAL: descByte = OSC_CFG_VALUE; // R10 R11
               OFS_STR: descByte = oscStr; // R10
               OFS_CFG_ATTR: descByte = oscAttr; // R12
               OFS_POWER: descByte = oscPower; // R13
               default: descByte = BYTE_ZERO;
            endcase
         end
      endcase
   endfunction

   // byte count is the shorter of descriptor and request
   assign reqDescLen = descLen(desc_sel_t'(reqSel));
   assign reqLimit = (reqLen < {8'h00, reqDescLen}) ? reqLen[7:0] :
      reqDescLen; // R15

   always_comb begin
      next_state = state;
      next_sel = sel;
      next_idx = idx;
      next_limit = limit;
      next_dataByte = dataByte;
      next_dataValid = dataValid;
      next_dataLast = dataLast;
      next_busy = busy;
      case (state)
         ST_IDLE: begin
            if (reqStart && reqLen != 16'h0000) begin
               next_state = ST_SEND;
               next_sel = desc_sel_t'(reqSel);
               next_idx = BYTE_ZERO;
               next_limit = reqLimit;
               next_dataByte = descByte(desc_sel_t'(reqSel), BYTE_ZERO);
               next_dataValid = 1'b1;
               next_dataLast = (reqLimit == ONE_BYTE); // R15
               next_busy = 1'b1;
            end
         end
         ST_SEND: begin
            if (dataReady) begin
               if (dataLast) begin
                  next_state = ST_IDLE;
                  next_dataValid = 1'b0;
                  next_dataLast = 1'b0;
                  next_dataByte = BYTE_ZERO;
                  next_busy = 1'b0;
               end else begin
                  next_idx = idx + ONE_BYTE; // R15
                  next_dataByte = descByte(sel, idx + ONE_BYTE); // R15
                  next_dataLast = (idx + TWO_BYTES == limit); // R15
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_dataValid = 1'b0;
            next_dataLast = 1'b0;
            next_busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
         sel <= SEL_BULK_IN;
         idx <= BYTE_ZERO;
         limit <= BYTE_ZERO;
         dataByte <= BYTE_ZERO;
         dataValid <= 1'b0;
         dataLast <= 1'b0;
         busy <= 1'b0;
      end else begin
         state <= next_state;
         sel <= next_sel;
         idx <= next_idx;
         limit <= next_limit;
         dataByte <= next_dataByte;
         dataValid <= next_dataValid;
         dataLast <= next_dataLast;
         busy <= next_busy;
      end
   end
endmodule // usb_desc_source

//--- usb_desc_source_assertions.sv
// checker for the descriptor source handshake
// bound onto usb_desc_source from the testbench top
`timescale 1ns/1ns
module usb_desc_source_assertions
   import usb_desc_pkg::*;
(
   input logic ref_clk,
   input logic nrst,
   input logic reqStart,
   input logic [1:0] reqSel,
   input logic [15:0] reqLen,
   input logic dataReady,
   input logic [7:0] dataByte,
   input logic dataValid,
   input logic dataLast,
   input logic busy
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence take_s;
      reqStart && !busy && reqLen != 16'h0000;
   endsequence
   sequence take2_s;
      reqStart && !busy && reqLen > 16'h0001 ##1 dataValid && dataReady;
   endsequence
   sequence last_s;
      dataValid && dataLast && dataReady;
   endsequence
   AST_ANSWER: assert property (take_s |=> dataValid && busy)
      else $error("no first byte after request");
   AST_FIRST: assert property (take_s |=> dataByte ==
      ($past(reqSel) == 2'h3 ? OSC_LEN : EP_LEN))
      else $error("wrong length byte");
   AST_TYPE: assert property (take2_s |=> dataValid && dataByte ==
      ($past(reqSel, 2) == 2'h3 ? OSC_TYPE : EP_TYPE))
      else $error("wrong type byte");
   AST_HOLD: assert property (dataValid && !dataReady |=> dataValid &&
      $stable(dataByte) && $stable(dataLast))
      else $error("byte changed while stalled");
   AST_END: assert property (last_s |=> !dataValid && !busy)
      else $error("transfer did not end");
   AST_ONE: assert property (reqStart && !busy && reqLen == 16'h0001
      |=> dataValid && dataLast)
      else $error("single byte not last");
   AST_ZERO: assert property (reqStart && !busy && reqLen == 16'h0000
      |=> !busy && !dataValid)
      else $error("zero length accepted");
   AST_BACK: assert property (dataValid && dataReady && !dataLast
      |=> dataValid)
      else $error("gap between bytes");
endmodule // usb_desc_source_assertions

//--- usb_host_model.sv
// host-side consumer model: accepts and records descriptor bytes
// stall makes it accept only every second cycle
`timescale 1ns/1ns
module usb_host_model (
   input logic ref_clk,
   input logic nrst,
   input logic stall,
   input logic clr,
   input logic dataValid,
   input logic [7:0] dataByte,
   output logic dataReady
);
   logic [7:0] rx [0:15];
   logic [7:0] n;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dataReady <= 1'b0;
         n <= 8'h00;
      end else begin
         dataReady <= stall ? ~dataReady : 1'b1;
         if (clr)
            n <= 8'h00;
         else if (dataValid && dataReady) begin
            rx[n[3:0]] <= dataByte;
            n <= n + 8'h01;
         end
      end
   end
endmodule // usb_host_model
